//--- rb_pkg.sv
// Purpose: shared constants and types of the remote bus responder
// Assumes: clk_sys at 100 MHz, 9600 baud 8N1 serial link
// Notes: attenuation is kept as binary tenths of a dB
package rb_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD   = 9600;
  localparam int BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
  localparam logic [7:0] STX = 8'h02, ETX = 8'h03, ACK = 8'h06, NAK = 8'h15;
  localparam logic [7:0] ADDR_MIN = 8'h31, ADDR_MAX = 8'h6F, ADDR_DEF = 8'h31;
  localparam logic [7:0] C_DEVNUM = 8'h30, C_POLL = 8'h31, C_FREQ = 8'h32;
  localparam logic [7:0] C_LATT = 8'h33, C_STEP = 8'h34, C_MASK = 8'h35;
  localparam logic [7:0] C_MUTE = 8'h36, C_IATT = 8'h37;
  localparam logic [7:0] CH_0 = 8'h30, CH_9 = 8'h39, CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B, CH_MINUS = 8'h2D, CH_2 = 8'h32;
  localparam int MAX_CMD = 9;
  localparam int MAX_RSP = 32;
  localparam logic [3:0] LEN_FREQ = 4'h9, LEN_ATT = 4'h4, LEN_MASK = 4'h8;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [5:0] RSP_ID = 6'h01, RSP_POLL = 6'h08, RSP_HDR = 6'h03;
  localparam int FRQ_DOT = 5;
  localparam logic [9:0] ATT_STEP = 10'h005, ATT_MAX = 10'h3E7;
  localparam logic [9:0] W_100 = 10'h064, W_10 = 10'h00A;
  localparam logic [1:0] RG_ADDR = 2'h0, RG_MASK = 2'h1, RG_STAT = 2'h2;
  localparam logic [1:0] RG_KEY = 2'h3;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;
  typedef enum logic [1:0] {
    MUTE_FORCE = 2'h0,
    MUTE_REL   = 2'h1,
    MUTE_AUTO  = 2'h2
  } mute_e;
  typedef struct packed {
    logic [31:0] freq;
    logic [9:0]  latt;
    logic [9:0]  iatt;
    mute_e       mute;
    logic [7:0]  mask;
  } settings_s;
  localparam settings_s SET_DEF = '{32'h0, 10'h0, 10'h0, MUTE_REL, 8'hFF};
endpackage

//--- uart_rx_byte.sv
// Purpose: 8N1 character receiver
// Assumes: rxd is an asynchronous pin
// Notes: a start bit that is gone at mid-bit is taken as a glitch
`timescale 1ns/1ps
`default_nettype none
module uart_rx_byte #(
  parameter int BAUD_DIV = rb_pkg::BIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       rxd,
  output logic [7:0]      rx_data,
  output logic            rx_valid
);
  logic [1:0]  sync_ff;
  logic [15:0] cnt_ff;
  logic [3:0]  bit_ff;
  logic        busy_ff;
  logic [7:0]  sh_ff;
  wire         line = sync_ff[1];
  wire         tick = busy_ff && (cnt_ff == 16'h0);
  // Bit 0 is the start sample, 1..8 data, 9 the stop bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_ff  <= 2'h3;
      cnt_ff   <= 16'h0;
      bit_ff   <= 4'h0;
      busy_ff  <= 1'b0;
      sh_ff    <= 8'h0;
      rx_data  <= 8'h0;
      rx_valid <= 1'b0;
    end else begin
      sync_ff  <= {sync_ff[0], rxd};
      rx_valid <= tick && (bit_ff == 4'h9) && line;
      if (!busy_ff && !line) begin
        busy_ff <= 1'b1;
        cnt_ff  <= 16'((BAUD_DIV - 1) / 2);
        bit_ff  <= 4'h0;
      end else if (busy_ff && !tick) begin
        cnt_ff <= cnt_ff - 16'h1;
      end else if (tick) begin
        cnt_ff <= 16'(BAUD_DIV - 1);
        bit_ff <= bit_ff + 4'h1;
        if ((bit_ff == 4'h0 && line) || bit_ff == 4'h9) begin
          busy_ff <= 1'b0;
        end
        if (bit_ff == 4'h9) begin
          rx_data <= sh_ff;
        end else if (bit_ff != 4'h0) begin
          sh_ff <= {line, sh_ff[7:1]};
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- uart_tx_byte.sv
// Purpose: 8N1 character transmitter
// Assumes: tx_start only while tx_busy is low
// Notes: tx_busy covers the whole stop bit
`timescale 1ns/1ps
`default_nettype none
module uart_tx_byte #(
  parameter int BAUD_DIV = rb_pkg::BIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_start,
  output logic            txd,
  output logic            tx_busy
);
  logic [9:0]  sh_ff;
  logic [3:0]  n_ff;
  logic [15:0] cnt_ff;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sh_ff   <= 10'h3FF;
      n_ff    <= 4'h0;
      cnt_ff  <= 16'h0;
      txd     <= 1'b1;
      tx_busy <= 1'b0;
    end else if (!tx_busy) begin
      if (tx_start) begin
        sh_ff   <= {1'b1, tx_data, 1'b0};
        n_ff    <= 4'hA;
        cnt_ff  <= 16'h0;
        tx_busy <= 1'b1;
      end
    end else if (cnt_ff != 16'h0) begin
      cnt_ff <= cnt_ff - 16'h1;
    end else if (n_ff == 4'h0) begin
      tx_busy <= 1'b0;
    end else begin
      txd    <= sh_ff[0];
      sh_ff  <= {1'b1, sh_ff[9:1]};
      n_ff   <= n_ff - 4'h1;
      cnt_ff <= 16'(BAUD_DIV - 1);
    end
  end
endmodule
`default_nettype wire

//--- remote_bus_responder.sv
// Purpose: addressed command frames, settings, mute and alarm outputs
// Assumes: rxd, nv_ok and alarm_pins are asynchronous pins
// Notes: a frame is judged only once its checksum char is in
`timescale 1ns/1ps
`default_nettype none
module remote_bus_responder #(
  parameter int         BAUD_DIV = rb_pkg::BIT_CYC,
  parameter logic [7:0] DEV_ID   = 8'h41 // Arbitrary identity char
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   txd_oe_n,
  input  wire logic [1:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic              nv_ok,
  input  wire rb_pkg::settings_s nv_set,
  input  wire logic [4:0]        alarm_pins,
  output rb_pkg::settings_s      cur_set,
  output logic [31:0]            freq_bcd,
  output logic                   mute_o,
  output logic                   mute_oe_n,
  output logic                   alarm_relay,
  output logic                   alarm_led
);
  if (BAUD_DIV < 16 || BAUD_DIV > 65535) begin : g_chk
    $error("BAUD_DIV out of range");
  end

  typedef enum logic [8:0] {
    S_BOOT = 9'h001,
    S_KEYW = 9'h002,
    S_IDLE = 9'h004,
    S_ADDR = 9'h008,
    S_CMD  = 9'h010,
    S_DATA = 9'h020,
    S_CSUM = 9'h040,
    S_EXEC = 9'h080,
    S_TX   = 9'h100
  } state_e;

  function automatic logic is_dig(input logic [7:0] c);
    return (c >= rb_pkg::CH_0) && (c <= rb_pkg::CH_9);
  endfunction

  function automatic logic [9:0] att_val(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] c);
    return 10'(a[3:0] * rb_pkg::W_100) + 10'(b[3:0] * rb_pkg::W_10)
         + {6'h0, c[3:0]};
  endfunction

  state_e            state_ff;
  logic [1:0]        boot_cnt_ff;
  logic              nv_err_ff;
  logic [5:0]        pin_s1_ff;
  logic [5:0]        pin_s2_ff;
  logic [7:0]        my_addr_ff;
  logic [7:0]        rx_addr_ff;
  logic [7:0]        cmd_ff;
  logic [3:0]        len_ff;
  logic [7:0]        sum_ff;
  logic [7:0]        chk_ff;
  logic [7:0]        buf_ff [rb_pkg::MAX_CMD];
  rb_pkg::settings_s set_ff;
  rb_pkg::settings_s nxt_set;
  logic [7:0]        stat_ff;
  logic [7:0]        ack_ff;
  logic [5:0]        dlen_ff;
  logic [5:0]        idx_ff;
  logic [7:0]        bits_ff;
  logic [7:0]        txsum_ff;
  logic              tx_start_ff;
  logic [7:0]        tx_dat_ff;
  logic              tx_busy;
  logic [7:0]        rx_byte;
  logic              rx_valid;
  logic              cmd_ok;
  logic              fmt_frq;
  logic              fmt_msk;
  logic [7:0]        new_mask;
  logic [7:0]        cur_byte;

  uart_rx_byte #(.BAUD_DIV(BAUD_DIV)) u_rx (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .rxd      (rxd),
    .rx_data  (rx_byte),
    .rx_valid (rx_valid)
  );

  uart_tx_byte #(.BAUD_DIV(BAUD_DIV)) u_tx (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .tx_data  (tx_dat_ff),
    .tx_start (tx_start_ff),
    .txd      (txd),
    .tx_busy  (tx_busy)
  );

  // Pins: nv_ok on bit 5, alarm_pins below it
  wire       nv_good = pin_s2_ff[5];
  wire [4:0] alm     = pin_s2_ff[4:0];
  wire       sum_alm = nv_err_ff
                     | (|({alm[4:1], 2'h0, alm[0]} & set_ff.mask[7:1]));
  wire [7:0] stat_w  = {alm[4:1], 2'h0, alm[0], sum_alm};
  wire       mute_on = (set_ff.mute == rb_pkg::MUTE_FORCE)
                     || (set_ff.mute == rb_pkg::MUTE_AUTO && sum_alm);

  wire       in_frm  = state_ff inside {S_IDLE, S_ADDR, S_CMD, S_DATA};
  wire       got_stx = rx_valid && in_frm && rx_byte == rb_pkg::STX;
  wire       hit     = rx_addr_ff == my_addr_ff;
  wire       sum_ok  = chk_ff == sum_ff;
  wire       exec_ok = hit && sum_ok && cmd_ok;
  wire       tx_go   = state_ff == S_TX && !tx_busy && !tx_start_ff;
  wire [5:0] last_ix = dlen_ff + rb_pkg::RSP_HDR + 6'h1;
  wire       key_wr  = reg_wr && reg_addr == rb_pkg::RG_KEY;
  wire       adr_wr  = reg_wr && reg_addr == rb_pkg::RG_ADDR
                     && reg_wdata >= rb_pkg::ADDR_MIN
                     && reg_wdata <= rb_pkg::ADDR_MAX;
  wire       msk_wr  = reg_wr && reg_addr == rb_pkg::RG_MASK;
  wire [9:0] att_new = att_val(buf_ff[0], buf_ff[1], buf_ff[3]);
  wire       fmt_att = len_ff == rb_pkg::LEN_ATT && is_dig(buf_ff[0])
                     && is_dig(buf_ff[1]) && buf_ff[2] == rb_pkg::CH_DOT
                     && is_dig(buf_ff[3]);
  wire       one     = len_ff == rb_pkg::LEN_ONE;
  wire       st_up   = buf_ff[0] == rb_pkg::CH_PLUS
                     && set_ff.latt <= rb_pkg::ATT_MAX - rb_pkg::ATT_STEP;
  wire       st_dn   = buf_ff[0] == rb_pkg::CH_MINUS
                     && set_ff.latt >= rb_pkg::ATT_STEP;

  // Field checks for the two long data strings
  always_comb begin
    fmt_frq  = len_ff == rb_pkg::LEN_FREQ;
    fmt_msk  = len_ff == rb_pkg::LEN_MASK;
    new_mask = 8'h0;
    for (int i = 0; i < rb_pkg::MAX_CMD; i++) begin
      if (i == rb_pkg::FRQ_DOT) begin
        fmt_frq = fmt_frq && buf_ff[i] == rb_pkg::CH_DOT;
      end else begin
        fmt_frq = fmt_frq && is_dig(buf_ff[i]);
      end
    end
    for (int i = 0; i < 8; i++) begin
      fmt_msk = fmt_msk && buf_ff[i][7:1] == rb_pkg::CH_0[7:1];
      new_mask[7 - i] = buf_ff[i][0];
    end
  end

  // Command decode; a code outside 0x30..0x37 is refused
  always_comb begin
    nxt_set = set_ff;
    cmd_ok  = 1'b0;
    unique case (cmd_ff)
      rb_pkg::C_DEVNUM, rb_pkg::C_POLL: begin
        cmd_ok = len_ff == 4'h0;
      end
      rb_pkg::C_FREQ: begin
        cmd_ok = fmt_frq;
        nxt_set.freq = {buf_ff[0][3:0], buf_ff[1][3:0], buf_ff[2][3:0],
                        buf_ff[3][3:0], buf_ff[4][3:0], buf_ff[6][3:0],
                        buf_ff[7][3:0], buf_ff[8][3:0]};
      end
      rb_pkg::C_LATT: begin
        cmd_ok = fmt_att;
        nxt_set.latt = att_new;
      end
      rb_pkg::C_IATT: begin
        cmd_ok = fmt_att;
        nxt_set.iatt = att_new;
      end
      rb_pkg::C_STEP: begin
        cmd_ok = one && (st_up || st_dn);
        nxt_set.latt = st_up ? set_ff.latt + rb_pkg::ATT_STEP
                             : set_ff.latt - rb_pkg::ATT_STEP;
      end
      rb_pkg::C_MASK: begin
        cmd_ok = fmt_msk;
        nxt_set.mask = new_mask;
      end
      rb_pkg::C_MUTE: begin
        cmd_ok = one && buf_ff[0] >= rb_pkg::CH_0
               && buf_ff[0] <= rb_pkg::CH_2;
        nxt_set.mute = rb_pkg::mute_e'(buf_ff[0][1:0]);
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // Reply character for the current position
  always_comb begin
    if (idx_ff == 6'h0) begin
      cur_byte = ack_ff;
    end else if (idx_ff == 6'h1) begin
      cur_byte = my_addr_ff;
    end else if (idx_ff == 6'h2) begin
      cur_byte = cmd_ff;
    end else if (idx_ff < dlen_ff + rb_pkg::RSP_HDR) begin
      cur_byte = (cmd_ff == rb_pkg::C_DEVNUM) ? DEV_ID
               : {rb_pkg::CH_0[7:1], bits_ff[7]};
    end else if (idx_ff == dlen_ff + rb_pkg::RSP_HDR) begin
      cur_byte = rb_pkg::ETX;
    end else begin
      cur_byte = txsum_ff;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= S_BOOT;
      boot_cnt_ff <= 2'h0;
      nv_err_ff   <= 1'b0;
      rx_addr_ff  <= 8'h0;
      cmd_ff      <= 8'h0;
      len_ff      <= 4'h0;
      sum_ff      <= 8'h0;
      chk_ff      <= 8'h0;
    end else begin
      if (state_ff == S_BOOT) begin
        boot_cnt_ff <= boot_cnt_ff + 2'h1;
        if (boot_cnt_ff == rb_pkg::BOOT_SETTLE) begin
          state_ff  <= nv_good ? S_IDLE : S_KEYW;
          nv_err_ff <= !nv_good;
        end
      end else if (state_ff == S_KEYW) begin
        if (key_wr) begin
          state_ff  <= S_IDLE;
          nv_err_ff <= 1'b0;
        end
      end else if (got_stx) begin
        state_ff <= S_ADDR;
        sum_ff   <= rb_pkg::STX;
        len_ff   <= 4'h0;
      end else if (rx_valid && state_ff != S_IDLE && in_frm) begin
        sum_ff <= sum_ff ^ rx_byte;
        unique case (state_ff)
          S_ADDR: begin
            rx_addr_ff <= rx_byte;
            state_ff   <= S_CMD;
          end
          S_CMD: begin
            cmd_ff   <= rx_byte;
            state_ff <= S_DATA;
          end
          S_DATA: begin
            if (rx_byte == rb_pkg::ETX) begin
              state_ff <= S_CSUM;
            end else if (len_ff == 4'(rb_pkg::MAX_CMD)) begin
              state_ff <= S_IDLE;
            end else begin
              len_ff <= len_ff + 4'h1;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end else if (rx_valid && state_ff == S_CSUM) begin
        chk_ff   <= rx_byte;
        state_ff <= S_EXEC;
      end else if (state_ff == S_EXEC) begin
        state_ff <= hit ? S_TX : S_IDLE;
      end else if (tx_go && idx_ff == last_ix + 6'h1) begin
        state_ff <= S_IDLE;
      end
    end
  end

  // Data characters need no reset
  always_ff @(posedge clk_sys) begin
    if (rx_valid && state_ff == S_DATA && rx_byte != rb_pkg::ETX
        && len_ff < 4'(rb_pkg::MAX_CMD)) begin
      buf_ff[len_ff] <= rx_byte;
    end
  end

  // Reply builder and transmit pacing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_ff      <= rb_pkg::NAK;
      dlen_ff     <= 6'h0;
      idx_ff      <= 6'h0;
      bits_ff     <= 8'h0;
      txsum_ff    <= 8'h0;
      tx_start_ff <= 1'b0;
      tx_dat_ff   <= 8'h0;
      txd_oe_n    <= 1'b1;
    end else begin
      tx_start_ff <= 1'b0;
      txd_oe_n    <= state_ff != S_TX;
      if (state_ff == S_EXEC) begin
        ack_ff   <= exec_ok ? rb_pkg::ACK : rb_pkg::NAK;
        idx_ff   <= 6'h0;
        txsum_ff <= 8'h0;
        bits_ff  <= stat_ff;
        dlen_ff  <= !exec_ok ? 6'h0
                  : cmd_ff == rb_pkg::C_DEVNUM ? rb_pkg::RSP_ID
                  : cmd_ff == rb_pkg::C_POLL ? rb_pkg::RSP_POLL : 6'h0;
      end else if (tx_go && idx_ff <= last_ix) begin
        tx_start_ff <= 1'b1;
        tx_dat_ff   <= cur_byte;
        txsum_ff    <= txsum_ff ^ cur_byte;
        idx_ff      <= idx_ff + 6'h1;
        if (idx_ff >= rb_pkg::RSP_HDR) begin
          bits_ff <= {bits_ff[6:0], 1'b0};
        end
      end else if (tx_go) begin
        idx_ff <= idx_ff + 6'h1;
      end
    end
  end

  // Settings, unit address and register port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      set_ff     <= rb_pkg::SET_DEF;
      my_addr_ff <= rb_pkg::ADDR_DEF;
      pin_s1_ff  <= 6'h0;
      pin_s2_ff  <= 6'h0;
      stat_ff    <= 8'h0;
      reg_rdata  <= 8'h0;
    end else begin
      pin_s1_ff <= {nv_ok, alarm_pins};
      pin_s2_ff <= pin_s1_ff;
      stat_ff   <= stat_w;
      if (state_ff == S_BOOT && boot_cnt_ff == rb_pkg::BOOT_SETTLE
          && nv_good) begin
        set_ff <= nv_set;
      end else if (state_ff == S_KEYW && key_wr) begin
        set_ff <= rb_pkg::SET_DEF;
      end else if (state_ff == S_EXEC && exec_ok) begin
        set_ff <= nxt_set;
      end else if (msk_wr) begin
        set_ff.mask <= reg_wdata;
      end
      if (adr_wr) begin
        my_addr_ff <= reg_wdata;
      end
      if (!reg_rd) begin
        reg_rdata <= 8'h0;
      end else begin
        unique case (reg_addr)
          rb_pkg::RG_ADDR: reg_rdata <= my_addr_ff;
          rb_pkg::RG_MASK: reg_rdata <= set_ff.mask;
          rb_pkg::RG_STAT: reg_rdata <= stat_ff;
          rb_pkg::RG_KEY:  reg_rdata <= {7'h0, state_ff == S_KEYW};
        endcase
      end
    end
  end

  // Pin drivers; the mute line is open drain
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_set     <= rb_pkg::SET_DEF;
      freq_bcd    <= 32'h0;
      mute_o      <= 1'b0;
      mute_oe_n   <= 1'b1;
      alarm_relay <= 1'b0;
      alarm_led   <= 1'b0;
    end else begin
      cur_set     <= set_ff;
      freq_bcd    <= set_ff.freq;
      mute_o      <= 1'b0;
      mute_oe_n   <= !mute_on;
      alarm_relay <= sum_alm;
      alarm_led   <= sum_alm;
    end
  end

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_ack;
    (state_ff == S_EXEC && exec_ok) |=> ack_ff == rb_pkg::ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("good frame not acked");

  property p_nak;
    (state_ff == S_EXEC && hit && !cmd_ok)
      |=> ack_ff == rb_pkg::NAK && state_ff == S_TX;
  endproperty
  a_nak: assert property (p_nak) else $error("bad command not nakked");

  property p_drop;
    (state_ff == S_EXEC && !hit) |=> state_ff == S_IDLE && $stable(set_ff);
  endproperty
  a_drop: assert property (p_drop) else $error("foreign frame acted on");

  property p_bad_sum;
    (state_ff == S_EXEC && hit && !sum_ok)
      |=> ack_ff == rb_pkg::NAK && $stable(set_ff);
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum used");

  property p_addr_char;
    (tx_go && idx_ff == 6'h1) |=> tx_start_ff && tx_dat_ff == my_addr_ff;
  endproperty
  a_addr_char: assert property (p_addr_char) else $error("reply address wrong");

  property p_etx;
    (tx_go && idx_ff == dlen_ff + rb_pkg::RSP_HDR)
      |=> tx_dat_ff == rb_pkg::ETX;
  endproperty
  a_etx: assert property (p_etx) else $error("reply not ended by ETX");

  property p_rsp_len;
    state_ff == S_TX |-> dlen_ff <= 6'(rb_pkg::MAX_RSP);
  endproperty
  a_rsp_len: assert property (p_rsp_len) else $error("reply data too long");

  property p_mute;
    (state_ff == S_EXEC && exec_ok && cmd_ff == rb_pkg::C_MUTE
     && buf_ff[0] == rb_pkg::CH_0) |=> ##1 !mute_oe_n && !mute_o;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not applied");

  property p_relay;
    $changed(sum_alm) |=> alarm_relay == $past(sum_alm) && alarm_led == alarm_relay;
  endproperty
  a_relay: assert property (p_relay) else $error("alarm relay lags");
endmodule
`default_nettype wire

//--- bus_host.sv
// Purpose: host model on the far side of the serial command bus
// Assumes: 8N1 characters, BAUD_DIV clock cycles per bit
// Notes: line_i is the bus level as seen by the host receiver
`timescale 1ns/1ps
`default_nettype none
module bus_host #(
  parameter int BAUD_DIV = 16
) (
  input  wire logic clk_sys,
  input  wire logic line_i,
  output var logic  line_o
);
  initial line_o = 1'b1;
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BAUD_DIV) @(posedge clk_sys);
    end
  endtask
  task automatic send(input logic [7:0] a, c, input logic [7:0] d[$], input bit bad);
    logic [7:0] f[$];
    logic [7:0] cs;
    f = {rb_pkg::STX, a, c};
    f = {f, d, rb_pkg::ETX};
    cs = 8'h00;
    foreach (f[i]) cs ^= f[i];
    f.push_back(cs ^ {7'h00, bad});
    foreach (f[i]) put(f[i]);
  endtask
  // Long wait: the reply only starts after the whole command has gone out
  task automatic get(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    b = 8'h00;
    while (line_i !== 1'b0 && n < 200 * BAUD_DIV) begin
      @(posedge clk_sys);
      n++;
    end
    ok = (n < 200 * BAUD_DIV);
    repeat (BAUD_DIV / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(posedge clk_sys);
      b[i] = line_i;
    end
    repeat (BAUD_DIV) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

//--- tb_remote_bus_responder.sv
// Purpose: self-checking bench of the remote bus responder
// Assumes: BAUD_DIV shortened to 16 cycles per bit
// Notes: released bus reads as idle high
`timescale 1ns/1ps
`default_nettype none
module tb_remote_bus_responder;
  typedef logic [7:0] bq_t[$];
  localparam logic [7:0] ID = 8'h5A; // Arbitrary identity char
  logic clk_sys, resetn, rxd, txd, txd_oe_n, reg_wr, reg_rd, nv_ok, mute_o, mute_oe_n;
  logic alarm_relay, alarm_led;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, unit, st;
  logic [4:0] alarm_pins;
  logic [31:0] freq_bcd;
  rb_pkg::settings_s nv_set, cur_set;
  int errors, n_checks, cyc;
  wire bus_line = txd_oe_n ? 1'b1 : txd;
  remote_bus_responder #(.BAUD_DIV(16), .DEV_ID(ID)) dut (.clk_sys, .resetn, .rxd, .txd,
    .txd_oe_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nv_ok, .nv_set,
    .alarm_pins, .cur_set, .freq_bcd, .mute_o, .mute_oe_n, .alarm_relay, .alarm_led);
  bus_host #(.BAUD_DIV(16)) host (.clk_sys(clk_sys), .line_i(bus_line), .line_o(rxd));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic bq_t s2q(input string s);
    bq_t q;
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
    return q;
  endfunction
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // kind: 0 no reply, 1 ACK with data rd, 2 NAK without data
  task automatic xfer(input logic [7:0] a, c, input bq_t d, input bit bad, input int kind,
                      input bq_t rdq);
    bq_t e;
    logic [7:0] b;
    bit ok;
    if (kind != 0) begin
      e = {(kind == 1) ? rb_pkg::ACK : rb_pkg::NAK, unit, c};
      if (kind == 1) e = {e, rdq};
      e.push_back(rb_pkg::ETX);
      b = 8'h00;
      foreach (e[i]) b ^= e[i];
      e.push_back(b);
    end
    fork
      host.send(a, c, d, bad);
      begin
        foreach (e[i]) begin
          host.get(b, ok);
          cmp("reply char", {1'b1, e[i]}, {ok, b});
        end
        if (kind == 0) begin
          host.get(b, ok);
          cmp("silence", 0, ok);
        end
      end
    join
    repeat (32) @(posedge clk_sys);
  endtask
  initial begin
    bq_t fq, sq;
    logic [31:0] fb;
    logic [7:0] v;
    void'($urandom(32'hD4F750F3));
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, alarm_pins} = '0;
    {errors, n_checks} = '0;
    nv_ok = 1'b1;
    nv_set = rb_pkg::SET_DEF;
    nv_set.freq = $urandom;
    unit = rb_pkg::ADDR_DEF;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    cmp("restored", 1, cur_set === nv_set);
    xfer(unit, rb_pkg::C_DEVNUM, s2q(""), 0, 1, '{ID});
    xfer(unit, rb_pkg::C_MUTE, s2q("2"), 0, 1, s2q(""));
    for (int k = 0; k < 2; k++) begin
      alarm_pins <= (k == 0) ? (5'h04 | 5'($urandom)) : 5'h00;
      repeat (6) @(posedge clk_sys);
      st = {alarm_pins[4:1], 2'b00, alarm_pins[0], 1'b0};
      st[0] = |st[7:1];
      sq = {};
      for (int i = 7; i >= 0; i--) sq.push_back(rb_pkg::CH_0 + {7'h00, st[i]});
      xfer(unit, rb_pkg::C_POLL, s2q(""), 0, 1, sq);
      cmp("relay", st[0], alarm_relay);
      cmp("led", st[0], alarm_led);
      cmp("auto mute", !st[0], mute_oe_n);
      rd(rb_pkg::RG_STAT, v);
      cmp("status reg", st, v);
    end
    alarm_pins <= 5'h1F;
    xfer(unit, rb_pkg::C_MASK, s2q("00000000"), 0, 1, s2q(""));
    cmp("masked relay", 0, alarm_relay);
    rd(rb_pkg::RG_MASK, v);
    cmp("mask reg", 8'h00, v);
    xfer(unit, rb_pkg::C_MASK, s2q("11111111"), 0, 1, s2q(""));
    cmp("unmasked relay", 1, alarm_relay);
    alarm_pins <= 5'h00;
    xfer(unit, rb_pkg::C_MUTE, s2q("0"), 0, 1, s2q(""));
    cmp("muted", 0, {mute_oe_n, mute_o});
    xfer(unit, rb_pkg::C_MUTE, s2q("1"), 0, 1, s2q(""));
    cmp("unmuted", 1, mute_oe_n);
    $display("test alarm and mute done");
    fb = 0;
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom % 10);
      fb = {fb[27:0], v[3:0]};
      if (i == 5) fq.push_back(rb_pkg::CH_DOT);
      fq.push_back(rb_pkg::CH_0 + v);
    end
    xfer(unit, rb_pkg::C_FREQ, fq, 0, 1, s2q(""));
    cmp("freq bcd", fb, freq_bcd);
    fq[0] = 8'h41;
    xfer(unit, rb_pkg::C_FREQ, fq, 0, 2, s2q(""));
    cmp("freq kept", fb, freq_bcd);
    xfer(unit, rb_pkg::C_LATT, s2q("99.9"), 0, 1, s2q(""));
    cmp("latt", 999, cur_set.latt);
    xfer(unit, rb_pkg::C_STEP, s2q("+"), 0, 2, s2q(""));
    xfer(unit, rb_pkg::C_STEP, s2q("-"), 0, 1, s2q(""));
    cmp("step", 994, cur_set.latt);
    xfer(unit, rb_pkg::C_IATT, s2q("07.3"), 0, 1, s2q(""));
    cmp("iatt", 73, cur_set.iatt);
    xfer(unit, rb_pkg::C_IATT, s2q("12.5"), 1, 2, s2q(""));
    cmp("iatt bad sum", 73, cur_set.iatt);
    xfer(8'h32, rb_pkg::C_IATT, s2q("12.5"), 0, 0, s2q(""));
    cmp("iatt other unit", 73, cur_set.iatt);
    $display("test settings done");
    wr(rb_pkg::RG_ADDR, 8'h70);
    rd(rb_pkg::RG_ADDR, v);
    cmp("addr reg", 8'h31, v);
    wr(rb_pkg::RG_ADDR, 8'h6F);
    unit = 8'h6F;
    xfer(unit, rb_pkg::C_DEVNUM, s2q(""), 0, 1, '{ID});
    $display("test address done");
    nv_ok <= 1'b0;
    resetn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    cmp("nv alarm", 1, alarm_led);
    rd(rb_pkg::RG_KEY, v);
    cmp("key wait", 1, v[0]);
    // Spoil the mask so that the key press must really reload defaults
    wr(rb_pkg::RG_MASK, 8'h00);
    wr(rb_pkg::RG_KEY, 8'h00);
    repeat (3) @(posedge clk_sys);
    cmp("defaults", 1, cur_set === rb_pkg::SET_DEF);
    cmp("alarm off", 0, alarm_led);
    $display("test boot done");
    give_verdict();
  end
endmodule
`default_nettype wire
